// File: hcp_pkg.sv
// host cpu port: shared constants and carrier types
// assumes one core clock; every host pin is already synchronous to it
package hcp_pkg;
  // ************************************************************
  // straps, read/write level and widths
  // ************************************************************
  localparam logic STRAP_SERIAL = 1'b0;
  localparam logic STRAP_PARALLEL = 1'b1;
  localparam logic WIDTH_16 = 1'b0;
  localparam logic WIDTH_32 = 1'b1;
  localparam logic RW_READ = 1'b1;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 24;
  // ************************************************************
  // serial frame layout: 32 header bits then 32 data bits, msb first
  // ************************************************************
  localparam int HDR_BITS = 32;
  localparam int FRAME_BITS = 64;
  localparam int HDR_RW_POS = 31;
  localparam logic [6:0] HDR_DONE = 7'h20;
  localparam logic [6:0] FRAME_DONE = 7'h40;
  // ************************************************************
  // reset values and lane masks
  // ************************************************************
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [23:0] ADDR_RST = 24'h00_0000;
  localparam logic [3:0] STRB_RST = 4'h0;
  localparam logic [3:0] STRB_LO16 = 4'h3;
  localparam logic [31:0] OE_LO16 = 32'h0000_ffff;
  localparam logic [31:0] OE_ALL = 32'hffff_ffff;
  localparam logic [31:0] OE_BIT0 = 32'h0000_0001;
  localparam logic [31:0] OE_NONE = 32'h0000_0000;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } hcp_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } hcp_rsp_t;

  localparam hcp_req_t REQ_RST = '{1'b0, 1'b0, ADDR_RST, DATA_RST, STRB_RST};
endpackage

// File: hcp_serial.sv
// host cpu port: serial slave engine
// assumes the serial pins are synchronous to core_clk and much slower than it,
// and that the register side answers a read before the next output edge
module hcp_serial
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // mode
  input wire logic active,
  // serial pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic serial_clock_phase,
  input wire logic serial_clock_polarity,
  output logic miso,
  // register side
  output hcp_pkg::hcp_req_t req,
  input wire hcp_pkg::hcp_rsp_t rsp
);
  import hcp_pkg::*;

  logic lvl_reg;
  logic [31:0] hdr_reg;
  logic [31:0] rx_reg;
  logic [31:0] tx_reg;
  logic [6:0] cnt_reg;
  logic lvl;
  logic lead;
  logic trail;
  logic cap;
  logic upd;
  logic in_frame;
  logic [6:0] cnt_next;

  // polarity folded in so that leading is always a rise of lvl
  assign lvl = sclk ^ serial_clock_polarity;
  assign lead = lvl & ~lvl_reg;
  assign trail = ~lvl & lvl_reg;
  assign cap = serial_clock_phase ? trail : lead;
  assign upd = serial_clock_phase ? lead : trail;
  assign in_frame = active & ~sel_n;
  assign cnt_next = cnt_reg + 7'h01;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      lvl_reg <= 1'b0;
    else
      lvl_reg <= lvl;
  end

  // ************************************************************
  // receive side
  // ************************************************************
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= '0;
      hdr_reg <= DATA_RST;
      rx_reg <= DATA_RST;
    end
    else if (!in_frame)
      cnt_reg <= '0;
    else if (cap && cnt_reg != FRAME_DONE)
    begin
      cnt_reg <= cnt_next;
      if (cnt_reg < HDR_DONE)
        hdr_reg <= {hdr_reg[30:0], mosi};
      else
        rx_reg <= {rx_reg[30:0], mosi};
    end
  end

  // one request per frame: read after the header, write after the data
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      req <= REQ_RST;
    else
    begin
      // the read flag is the first header bit, one place short of the top
      // until the last header bit has been shifted in
      req.rd <= in_frame & cap & (cnt_next == HDR_DONE) & hdr_reg[HDR_RW_POS - 1];
      req.wr <= in_frame & cap & (cnt_next == FRAME_DONE) & ~hdr_reg[HDR_RW_POS];
      req.addr <= hdr_reg[23:0];
      if (cnt_reg == HDR_DONE - 7'h01)
        req.addr <= {hdr_reg[22:0], mosi};
      req.wdata <= {rx_reg[30:0], mosi};
      req.wstrb <= 4'hf;
    end
  end

  // ************************************************************
  // transmit side
  // ************************************************************
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_reg <= DATA_RST;
      miso <= 1'b0;
    end
    else if (!in_frame)
    begin
      tx_reg <= DATA_RST;
      miso <= 1'b0;
    end
    else if (rsp.ack)
      tx_reg <= rsp.rdata;
    else if (upd && cnt_reg >= HDR_DONE)
    begin
      miso <= tx_reg[31];
      tx_reg <= {tx_reg[30:0], 1'b0};
    end
  end
endmodule

// File: hcp_top.sv
// host cpu port: parallel or serial access to the internal registers
// assumes host pins are synchronous to core_clk; pad logic resolves the
// three-signal two-way pins
//
// Operation
// - host-select strap low picks serial, high picks parallel access
// - width strap low gives 16-bit bus, high 32-bit; ignored in serial
// - 32-bit parallel mode uses all data lines both ways, bit 31 msb
// - 16-bit mode uses data lines 15..0 only; host ties upper lines
// - serial mode ignores parallel data and address lines except serial out
// - data line 0 is parallel bit 0, or serial output in serial mode
// - parallel chip select low for each access; ignored in serial mode
// - read/write pin level decides register read or write in parallel mode
// - phase 0 captures on leading edge, updates output on trailing edge
// - phase 1 captures on trailing edge, updates output on leading edge
// - polarity 0 idles clock low, 1 idles it high
// - ready pulled low when access may finish; host waits for it
module hcp_top
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // straps
  input wire logic host_cpu_spi_n,
  input wire logic bus_width_select,
  // host data bus, three-signal form
  input wire logic [31:0] hd_in,
  output logic [31:0] hd_out,
  output logic [31:0] hd_oe,
  // host address and controls
  input wire logic [24:1] host_addr,
  input wire logic host_cs_n,
  input wire logic host_rd_wr,
  input wire logic [3:0] host_wr_be_n,
  // ready, actively driven high before release
  output logic host_ready_n_out,
  output logic host_ready_n_oe,
  // register side
  output hcp_pkg::hcp_req_t reg_req,
  input wire hcp_pkg::hcp_rsp_t reg_rsp
);
  import hcp_pkg::*;

  typedef enum {P_IDLE, P_REQ, P_WAIT, P_READY, P_RELEASE} hcp_pstate_t;

  hcp_pstate_t pstate_reg;
  logic strap_taken_reg;
  logic serial_mode_reg;
  logic wide_reg;
  logic [31:0] rdata_reg;
  logic read_reg;
  hcp_req_t par_req;
  hcp_req_t ser_req;
  hcp_rsp_t ser_rsp;
  logic ser_miso;
  logic [31:0] lane_oe;

  // ************************************************************
  // strap capture
  // ************************************************************
  // straps are caught once, on the first edge after reset release
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_taken_reg <= 1'b0;
      serial_mode_reg <= 1'b0;
      wide_reg <= WIDTH_32;
    end
    else if (!strap_taken_reg)
    begin
      strap_taken_reg <= 1'b1;
      serial_mode_reg <= (host_cpu_spi_n == STRAP_SERIAL);
      wide_reg <= (bus_width_select == WIDTH_32);
    end
  end

  // ************************************************************
  // parallel access sequencer
  // ************************************************************
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pstate_reg <= P_IDLE;
      read_reg <= 1'b0;
    end
    else if (!strap_taken_reg || serial_mode_reg)
      pstate_reg <= P_IDLE;
    else
    begin
      case (pstate_reg)
        P_IDLE:
        begin
          if (!host_cs_n)
          begin
            pstate_reg <= P_REQ;
            read_reg <= (host_rd_wr == RW_READ);
          end
        end
        P_REQ:
          pstate_reg <= P_WAIT;
        P_WAIT:
        begin
          if (reg_rsp.ack)
            pstate_reg <= P_READY;
        end
        P_READY:
        begin
          // the host may only end the access once ready is seen
          if (host_cs_n)
            pstate_reg <= P_RELEASE;
        end
        P_RELEASE:
          pstate_reg <= P_IDLE;
        default:
          pstate_reg <= P_IDLE;
      endcase
    end
  end

  // request built from the pins; narrow mode keeps only the low lanes
  always_comb
  begin
    par_req = REQ_RST;
    par_req.rd = (pstate_reg == P_IDLE) & ~host_cs_n & (host_rd_wr == RW_READ);
    par_req.wr = (pstate_reg == P_IDLE) & ~host_cs_n & (host_rd_wr != RW_READ);
    // all 24 address lines, line 1 as bit 0; the host holds it low in wide mode
    par_req.addr = host_addr;
    if (wide_reg)
    begin
      par_req.wdata = hd_in;
      par_req.wstrb = ~host_wr_be_n;
    end
    else
    begin
      par_req.wdata = {16'h0000, hd_in[15:0]};
      par_req.wstrb = ~host_wr_be_n & STRB_LO16;
    end
  end

  // ************************************************************
  // serial engine
  // ************************************************************
  // serial pins share the write-enable and read/write pads
  hcp_serial u_serial
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .active(serial_mode_reg & strap_taken_reg),
    .sclk(host_wr_be_n[0]),
    .mosi(host_wr_be_n[1]),
    .sel_n(host_wr_be_n[2]),
    .serial_clock_phase(host_rd_wr),
    .serial_clock_polarity(host_wr_be_n[3]),
    .miso(ser_miso),
    .req(ser_req),
    .rsp(ser_rsp)
  );

  always_comb
  begin
    ser_rsp = reg_rsp;
    ser_rsp.ack = reg_rsp.ack & serial_mode_reg;
  end

  // ************************************************************
  // register side request
  // ************************************************************
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_req <= REQ_RST;
    else if (!strap_taken_reg)
      reg_req <= REQ_RST;
    else if (serial_mode_reg)
      reg_req <= ser_req;
    else
      reg_req <= par_req;
  end

  // ************************************************************
  // read data and pad drive
  // ************************************************************
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_reg <= DATA_RST;
    else if (pstate_reg == P_WAIT && reg_rsp.ack)
      rdata_reg <= wide_reg ? reg_rsp.rdata : {16'h0000, reg_rsp.rdata[15:0]};
  end

  assign lane_oe = wide_reg ? OE_ALL : OE_LO16;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hd_out <= DATA_RST;
      hd_oe <= OE_NONE;
    end
    else if (serial_mode_reg)
    begin
      // only line 0 is driven, as the serial output, while selected
      hd_out <= {31'h0000_0000, ser_miso};
      hd_oe <= host_wr_be_n[2] ? OE_NONE : OE_BIT0;
    end
    else if (pstate_reg == P_READY && read_reg && !host_cs_n)
    begin
      hd_out <= rdata_reg;
      hd_oe <= lane_oe;
    end
    else
    begin
      hd_out <= DATA_RST;
      hd_oe <= OE_NONE;
    end
  end

  // ready is driven high for two cycles before release so the pull-up
  // does not have to recharge the line on its own
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      host_ready_n_out <= 1'b1;
      host_ready_n_oe <= 1'b0;
    end
    else if (pstate_reg == P_READY && !host_cs_n)
    begin
      host_ready_n_out <= 1'b0;
      host_ready_n_oe <= 1'b1;
    end
    else if (pstate_reg == P_READY || pstate_reg == P_RELEASE)
    begin
      host_ready_n_out <= 1'b1;
      host_ready_n_oe <= 1'b1;
    end
    else
    begin
      host_ready_n_out <= 1'b1;
      host_ready_n_oe <= 1'b0;
    end
  end
endmodule

// File: hcp_top_properties.sv
// port checker for hcp_top
// assumes one core clock; bound to every hcp_top instance
module hcp_top_properties
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // straps and host pins
  input wire logic host_cpu_spi_n,
  input wire logic bus_width_select,
  input wire logic [31:0] hd_oe,
  input wire logic [24:1] host_addr,
  input wire logic host_cs_n,
  input wire logic host_rd_wr,
  input wire logic host_ready_n_out,
  input wire logic host_ready_n_oe,
  // register side
  input wire hcp_pkg::hcp_req_t reg_req,
  input wire hcp_pkg::hcp_rsp_t reg_rsp
);
  import hcp_pkg::*;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // ****
  // mode gating
  // ****
  ready_par_only_a:
    assert property (host_ready_n_oe |-> host_cpu_spi_n) else $error("ready driven in serial");
  serial_oe_a:
    assert property (!host_cpu_spi_n |-> hd_oe[31:1] == 31'h0) else $error("serial drives bus");
  narrow_oe_a:
    assert property (host_cpu_spi_n && !bus_width_select |-> hd_oe[31:16] == 16'h0)
    else $error("upper lines driven in 16-bit");
  // ****
  // parallel requests and ready
  // ****
  rd_level_a:
    assert property (host_cpu_spi_n && reg_req.rd |-> $past(host_rd_wr) == RW_READ)
    else $error("read without read level");
  wr_level_a:
    assert property (host_cpu_spi_n && reg_req.wr |-> $past(host_rd_wr) != RW_READ)
    else $error("write without write level");
  select_gate_a:
    assert property (host_cpu_spi_n && (reg_req.rd || reg_req.wr) |-> !$past(host_cs_n))
    else $error("request without select");
  req_addr_a:
    assert property (host_cpu_spi_n && (reg_req.rd || reg_req.wr)
      |-> reg_req.addr == $past(host_addr)) else $error("address mismatch");
  ack_ready_a:
    assert property (host_cpu_spi_n && reg_rsp.ack |-> ##2 host_ready_n_oe && !host_ready_n_out)
    else $error("no ready after answer");
  ready_hold_a:
    assert property (host_ready_n_oe && !host_ready_n_out && !host_cs_n |=> !host_ready_n_out)
    else $error("ready dropped early");
  ready_release_a:
    assert property (host_ready_n_oe && !host_ready_n_out && host_cs_n
      |=> host_ready_n_oe && host_ready_n_out) else $error("ready not driven high");
endmodule

bind hcp_top hcp_top_properties u_hcp_top_properties (.core_clk, .arst_n, .host_cpu_spi_n,
  .bus_width_select, .hd_oe, .host_addr, .host_cs_n, .host_rd_wr, .host_ready_n_out,
  .host_ready_n_oe, .reg_req, .reg_rsp);

// File: hcp_reg_model.sv
// register-side stand-in: sixteen words answering one request at a time
// assumes rd or wr pulses one cycle per access
module hcp_reg_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // pacing
  input wire logic slow,
  // register side
  input wire hcp_pkg::hcp_req_t req,
  output hcp_pkg::hcp_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import hcp_pkg::*;
  logic [31:0] mem_reg [16];
  logic [2:0] wait_reg;
  logic busy_reg;
  logic rd_reg;
  logic [3:0] idx_reg;
  always_ff @(posedge core_clk)
  begin
    for (int b = 0; b < 4; b++)
    begin
      if (req.wr && req.wstrb[b])
        mem_reg[req.addr[5:2]][b*8 +: 8] <= req.wdata[b*8 +: 8];
    end
  end
  // read data churns outside a read answer so a stale sample shows
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp <= '0;
      busy_reg <= 1'b0;
      wait_reg <= 3'h0;
      rd_reg <= 1'b0;
      idx_reg <= 4'h0;
    end
    else
    begin
      rsp.ack <= 1'b0;
      rsp.rdata <= ~rsp.rdata;
      if (req.rd || req.wr)
      begin
        busy_reg <= 1'b1;
        wait_reg <= slow ? 3'h5 : 3'h0;
        rd_reg <= req.rd;
        idx_reg <= req.addr[5:2];
      end
      else if (busy_reg && wait_reg == 3'h0)
      begin
        busy_reg <= 1'b0;
        rsp.ack <= 1'b1;
        if (rd_reg)
          rsp.rdata <= mem_reg[idx_reg];
      end
      else if (busy_reg)
        wait_reg <= wait_reg - 3'h1;
    end
  end
endmodule

// File: hcp_top_bench.sv
// testbench for hcp_top: parallel 32/16 and all four serial modes
// assumes hcp_reg_model answers on the register side
module hcp_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import hcp_pkg::*;
  localparam int HALF = 8;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic host_cpu_spi_n = 1'b1;
  logic bus_width_select = 1'b1;
  logic [31:0] hd_in = 32'h0;
  logic [24:1] host_addr = 24'h0;
  logic host_cs_n = 1'b1;
  logic host_rd_wr = 1'b1;
  logic [3:0] host_wr_be_n = 4'hf;
  logic slow = 1'b0;
  logic [31:0] hd_out, hd_oe, rd, oe;
  logic host_ready_n_out, host_ready_n_oe;
  logic [63:0] rx;
  hcp_req_t reg_req;
  hcp_rsp_t reg_rsp;
  int bad_count = 0;
  int tests_run = 0;
  always #5 core_clk = ~core_clk;
  hcp_top u_hcp_top (.core_clk, .arst_n, .host_cpu_spi_n, .bus_width_select, .hd_in, .hd_out,
    .hd_oe, .host_addr, .host_cs_n, .host_rd_wr, .host_wr_be_n, .host_ready_n_out,
    .host_ready_n_oe, .reg_req, .reg_rsp);
  hcp_reg_model u_hcp_reg_model (.core_clk, .arst_n, .slow, .req(reg_req), .rsp(reg_rsp));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // straps only change inside reset; parallel select sits low in serial
  task rst(input logic spi, input logic w, input logic cp, input logic pol);
    arst_n = 1'b0;
    host_cpu_spi_n = spi;
    bus_width_select = w;
    host_rd_wr = cp;
    host_cs_n = spi;
    host_wr_be_n = {pol, 2'b11, pol};
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask
  task par(input logic rw, input logic [24:1] a, input logic [31:0] d, input logic [3:0] be,
    output logic [31:0] q, output logic [31:0] o);
    int n;
    @(negedge core_clk);
    host_rd_wr = rw;
    host_addr = a;
    hd_in = d;
    host_wr_be_n = be;
    host_cs_n = 1'b0;
    n = 0;
    while ((host_ready_n_out !== 1'b0 || host_ready_n_oe !== 1'b1) && n < 50)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("ready", 32'h0, {31'h0, host_ready_n_out});
    q = hd_out;
    o = hd_oe;
    host_cs_n = 1'b1;
    hd_in = ~d;
    repeat (4) @(negedge core_clk);
  endtask
  task spi(input logic [63:0] tx, output logic [63:0] q);
    logic cp, pol;
    cp = host_rd_wr;
    pol = host_wr_be_n[3];
    host_wr_be_n[2] = 1'b0;
    // data moves on the edge opposite to the one the device captures on
    for (int i = 63; i >= 0; i--)
    begin
      if (!cp)
        host_wr_be_n[1] = tx[i];
      repeat (HALF) @(negedge core_clk);
      if (!cp)
        q[i] = hd_out[0];
      host_wr_be_n[0] = ~pol;
      if (cp)
        host_wr_be_n[1] = tx[i];
      repeat (HALF) @(negedge core_clk);
      if (cp)
        q[i] = hd_out[0];
      host_wr_be_n[0] = pol;
    end
    repeat (HALF) @(negedge core_clk);
    host_wr_be_n[2] = 1'b1;
    host_wr_be_n[1] = ~tx[0];
    repeat (HALF) @(negedge core_clk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #300_000;
    bad_count++;
    wrap_up;
  end
  initial
  begin
    rst(1'b1, 1'b1, 1'b0, 1'b0);
    slow = 1'b1;
    par(1'b0, 24'h8, 32'ha5c3_1e87, 4'h0, rd, oe);
    slow = 1'b0;
    par(1'b0, 24'h8, 32'h0, 4'he, rd, oe);
    par(1'b1, 24'h8, 32'h0, 4'h0, rd, oe);
    chk("rd32", 32'ha5c3_1e00, rd);
    chk("oe32", 32'hffff_ffff, oe);
    $display("test par32 done");
    rst(1'b1, 1'b0, 1'b0, 1'b0);
    par(1'b0, 24'h6, 32'hdead_1234, 4'h0, rd, oe);
    par(1'b1, 24'h6, 32'hbeef_0000, 4'h0, rd, oe);
    chk("rd16", 32'h0000_1234, rd);
    chk("oe16", 32'h0000_ffff, oe);
    $display("test par16 done");
    // width strap flips per mode; serial must not care
    for (int m = 0; m < 4; m++)
    begin
      rst(1'b0, ~m[0], m[0], m[1]);
      spi({8'h00, 24'h24, 32'h8e3b_59c1 ^ m}, rx);
      spi({8'h80, 24'h24, 32'hffff_ffff}, rx);
      chk("spi_rd", 32'h8e3b_59c1 ^ m, rx[31:0]);
      chk("spi_hdr", 32'h0, rx[63:32]);
      $display("test spi mode %0d done", m);
    end
    wrap_up;
  end
endmodule
